// file: src/phy_irq_pkg.sv
package phy_irq_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int EVT_N = 4;

	// ----------------------------------------
	// Management register addresses
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_EVT_ENABLE = 5'h12;
	localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 5'h13;

	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	// Event vector index, also offset from BIT_EVT_LO in the enable register; in the status register only for LINK, DUPLEX and RATE
	localparam int EVT_LINK = 0;
	localparam int EVT_DUPLEX = 1;
	localparam int EVT_RATE = 2;
	localparam int EVT_NEG = 3;
	localparam int BIT_EVT_LO = 4;
	localparam int BIT_NEG_DONE = 7;
	localparam int BIT_PENDING = 2;
	localparam int BIT_GLOBAL_EN = 1;
	localparam int BIT_FORCE = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [EVT_N-1:0] EVT_ZERO = 4'h0;

endpackage

// file: src/evt_if.sv
`timescale 1ns/1ps
interface evt_if #(
	parameter int N = 4
);
	logic [N-1:0] change;
	logic clear;
	logic [N-1:0] latched;

	modport ctrl (
		output change,
		output clear,
		input latched
	);
	modport keep (
		input change,
		input clear,
		output latched
	);
endinterface

// file: src/event_latch.sv
`timescale 1ns/1ps
module event_latch #(
	parameter int N = 4
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	evt_if.keep e
);

	if (N < 1) begin : g_bad_n
		$error("event_latch needs at least one event");
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	// ----------------------------------------
	// Sticky event bits
	// ----------------------------------------
	for (genvar g = 0; g < N; g++) begin : g_bit
		logic bit_ff;
		logic nxt_bit;

		always_comb begin
			nxt_bit = e.change[g] | (bit_ff & ~e.clear);
		end

		always_ff @(posedge i_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				bit_ff <= 1'b0;
			end else begin
				bit_ff <= nxt_bit;
			end
		end

		assign e.latched[g] = bit_ff;

		a_set_wins_clear: assert property (
			e.change[g] |=> e.latched[g]
		) else $error("event lost while being cleared");

		a_hold_until_read: assert property (
			e.latched[g] && !e.clear |=> e.latched[g]
		) else $error("event bit dropped without a read");
	end

endmodule

// file: src/phy_interrupt_status.sv
`timescale 1ns/1ps
module phy_interrupt_status (
	input wire logic I_REF_CLK,
	input wire logic I_RSTN,
	input wire logic I_NEGOTIATION_FINISHED,
	input wire logic I_RATE_100,
	input wire logic I_FULL_DUPLEX,
	input wire logic I_LINK_UP,
	input wire logic [phy_irq_pkg::ADDR_W-1:0] I_REG_ADDR,
	input wire logic I_REG_RD,
	input wire logic I_REG_WR,
	input wire logic [phy_irq_pkg::DATA_W-1:0] I_REG_WDATA,
	output logic [phy_irq_pkg::DATA_W-1:0] O_REG_RDATA,
	output logic O_MGMT_IRQ_OUT
);

	localparam int N = phy_irq_pkg::EVT_N;
	localparam int LO = phy_irq_pkg::BIT_EVT_LO;

	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RSTN);

	evt_if #(.N(N)) evt ();

	event_latch #(.N(N)) u_latch (
		.i_clk(I_REF_CLK),
		.i_rstn(I_RSTN),
		.e(evt.keep)
	);

	// ----------------------------------------
	// Change detection
	// ----------------------------------------
	logic [N-1:0] cur;
	logic [N-1:0] prev_ff;
	logic [N-1:0] nxt_prev;
	logic primed_ff;
	logic nxt_primed;
	logic [N-1:0] chg;

	always_comb begin
		cur = phy_irq_pkg::EVT_ZERO;
		cur[phy_irq_pkg::EVT_NEG] = I_NEGOTIATION_FINISHED;
		cur[phy_irq_pkg::EVT_RATE] = I_RATE_100;
		cur[phy_irq_pkg::EVT_DUPLEX] = I_FULL_DUPLEX;
		cur[phy_irq_pkg::EVT_LINK] = I_LINK_UP;
	end

	// First cycle after reset only samples, so a static input level
	// is not mistaken for a change.
	// rate, duplex and link changes
	always_comb begin
		nxt_prev = cur;
		nxt_primed = 1'b1;
		chg = cur ^ prev_ff;
		// Negotiation raises an event only on completion
		chg[phy_irq_pkg::EVT_NEG] = cur[phy_irq_pkg::EVT_NEG] &
			~prev_ff[phy_irq_pkg::EVT_NEG];
		if (!primed_ff) begin
			chg = phy_irq_pkg::EVT_ZERO;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			prev_ff <= '0;
			primed_ff <= 1'b0;
		end else begin
			prev_ff <= nxt_prev;
			primed_ff <= nxt_primed;
		end
	end

	logic rd_status;

	assign rd_status = I_REG_RD &&
		(I_REG_ADDR == phy_irq_pkg::ADDR_EVT_STATUS);
	assign evt.change = chg;
	assign evt.clear = rd_status;

	// ----------------------------------------
	// Enable register
	// ----------------------------------------
	logic [N-1:0] mask_ff;
	logic [N-1:0] nxt_mask;
	logic gen_ff;
	logic nxt_gen;
	logic force_ff;
	logic nxt_force;

	always_comb begin
		nxt_mask = mask_ff;
		nxt_gen = gen_ff;
		nxt_force = force_ff;
		if (I_REG_WR && (I_REG_ADDR == phy_irq_pkg::ADDR_EVT_ENABLE)) begin
			nxt_mask = I_REG_WDATA[LO +: N];
			nxt_gen = I_REG_WDATA[phy_irq_pkg::BIT_GLOBAL_EN];
			nxt_force = I_REG_WDATA[phy_irq_pkg::BIT_FORCE];
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			mask_ff <= '0;
			gen_ff <= 1'b0;
			force_ff <= 1'b0;
		end else begin
			mask_ff <= nxt_mask;
			gen_ff <= nxt_gen;
			force_ff <= nxt_force;
		end
	end

	// ----------------------------------------
	// Pending, interrupt and read data
	// ----------------------------------------
	logic pending;
	logic [phy_irq_pkg::DATA_W-1:0] status_word;
	logic [phy_irq_pkg::DATA_W-1:0] enable_word;
	logic [phy_irq_pkg::DATA_W-1:0] rdata_ff;
	logic [phy_irq_pkg::DATA_W-1:0] nxt_rdata;
	logic irq_ff;
	logic nxt_irq;

	// pending from unmasked latched events while globally enabled, or force
	assign pending = force_ff | (gen_ff & (|(evt.latched & mask_ff)));

	always_comb begin
		status_word = phy_irq_pkg::WORD_ZERO;
		enable_word = phy_irq_pkg::WORD_ZERO;
		status_word[phy_irq_pkg::BIT_NEG_DONE] = cur[phy_irq_pkg::EVT_NEG];
		status_word[LO +: phy_irq_pkg::EVT_NEG] =
			evt.latched[phy_irq_pkg::EVT_NEG-1:0];
		status_word[phy_irq_pkg::BIT_PENDING] = pending;
		enable_word[LO +: N] = mask_ff;
		enable_word[phy_irq_pkg::BIT_GLOBAL_EN] = gen_ff;
		enable_word[phy_irq_pkg::BIT_FORCE] = force_ff;
	end

	always_comb begin
		nxt_rdata = rdata_ff;
		nxt_irq = pending;
		if (I_REG_RD) begin
			case (I_REG_ADDR)
				phy_irq_pkg::ADDR_EVT_STATUS: nxt_rdata = status_word;
				phy_irq_pkg::ADDR_EVT_ENABLE: nxt_rdata = enable_word;
				default: nxt_rdata = phy_irq_pkg::WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rdata_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
		end
	end

	assign O_REG_RDATA = rdata_ff;
	assign O_MGMT_IRQ_OUT = irq_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------

	a_status_upper_zero: assert property (
		rd_status |=> (O_REG_RDATA[15:8] == 8'h00) &&
			(O_REG_RDATA[3] == 1'b0) && (O_REG_RDATA[1:0] == 2'b00)
	) else $error("unused status bits not zero");

	a_neg_done_live: assert property (
		rd_status |=> O_REG_RDATA[phy_irq_pkg::BIT_NEG_DONE] ==
			$past(I_NEGOTIATION_FINISHED)
	) else $error("completion bit does not follow state");

	a_rate_read_clears: assert property (
		rd_status && !chg[phy_irq_pkg::EVT_RATE] ##1
			!chg[phy_irq_pkg::EVT_RATE] ##1 rd_status |=>
			!O_REG_RDATA[LO + phy_irq_pkg::EVT_RATE]
	) else $error("rate change bit not cleared by read");

	a_duplex_read_clears: assert property (
		rd_status && !chg[phy_irq_pkg::EVT_DUPLEX] |=>
			!evt.latched[phy_irq_pkg::EVT_DUPLEX]
	) else $error("duplex change bit not cleared by read");

	a_link_change_seen: assert property (
		primed_ff && $changed(I_LINK_UP) ##1 !rd_status ##1 rd_status |=>
			O_REG_RDATA[LO + phy_irq_pkg::EVT_LINK]
	) else $error("link change not reported");

	a_read_returns_events: assert property (
		rd_status |=> O_REG_RDATA[6:4] == $past(evt.latched[2:0])
	) else $error("read data does not hold captured events");

	a_pending_bit: assert property (
		rd_status |=> O_REG_RDATA[phy_irq_pkg::BIT_PENDING] ==
			$past(pending)
	) else $error("pending bit wrong");

	a_mask_blocks_irq: assert property (
		!force_ff && ((evt.latched & mask_ff) == '0) |=> !O_MGMT_IRQ_OUT
	) else $error("masked event raised interrupt");

	a_global_disable: assert property (
		!gen_ff && !force_ff |=> !O_MGMT_IRQ_OUT
	) else $error("interrupt while globally disabled");

	a_force_irq: assert property (
		force_ff [*2] |=> O_MGMT_IRQ_OUT [*1]
	) else $error("force bit did not assert interrupt");

	a_irq_follows_pending: assert property (
		O_MGMT_IRQ_OUT == $past(pending)
	) else $error("interrupt output not following pending");

endmodule

// file: test/mgmt_station.sv
`timescale 1ns/1ps
// Management side: one strobe per access, a spare edge after each
module mgmt_station (
	input wire logic i_clk,
	input wire logic [phy_irq_pkg::DATA_W-1:0] i_rdata,
	output logic [phy_irq_pkg::ADDR_W-1:0] o_addr,
	output logic o_rd,
	output logic o_wr,
	output logic [phy_irq_pkg::DATA_W-1:0] o_wdata
);
	initial begin
		o_addr = 5'h00;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 16'h0000;
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(posedge i_clk);
		#1;
		o_wr = 1'b0;
		// Stale data is inverted so nothing relies on it after the strobe
		o_wdata = ~d;
		@(posedge i_clk);
		#1;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		o_addr = a;
		o_rd = 1'b1;
		@(posedge i_clk);
		#1;
		d = i_rdata;
		o_rd = 1'b0;
		@(posedge i_clk);
		#1;
	endtask
endmodule

// file: test/test_phy_interrupt_status.sv
`timescale 1ns/1ps
module test_phy_interrupt_status;
	logic clk;
	logic rstn;
	logic neg;
	logic rate;
	logic dup;
	logic link;
	logic [4:0] addr;
	logic rd;
	logic wr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic irq;
	logic [15:0] v;
	int mismatches;
	int checks_done;
	int cycles;
	// ----------------------------------------
	// Clock, device, station
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	phy_interrupt_status dut_u (.I_REF_CLK(clk), .I_RSTN(rstn),
		.I_NEGOTIATION_FINISHED(neg), .I_RATE_100(rate),
		.I_FULL_DUPLEX(dup), .I_LINK_UP(link), .I_REG_ADDR(addr),
		.I_REG_RD(rd), .I_REG_WR(wr), .I_REG_WDATA(wdata),
		.O_REG_RDATA(rdata), .O_MGMT_IRQ_OUT(irq));
	mgmt_station sta (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
		.o_rd(rd), .o_wr(wr), .o_wdata(wdata));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic cmp(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk_st(input logic [15:0] e);
		sta.rd(phy_irq_pkg::ADDR_EVT_STATUS, v);
		cmp("status", e, v);
	endtask
	task automatic chk_irq(input logic e);
		cmp("irq", {15'h0000, e}, {15'h0000, irq});
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk_st(16'h0000);
		sta.rd(phy_irq_pkg::ADDR_EVT_ENABLE, v);
		cmp("enable", 16'h0000, v);
		chk_irq(1'b0);
	endtask
	task automatic t_events();
		link = ~link;
		dup = ~dup;
		rate = ~rate;
		cyc(2);
		chk_st(16'h0070);
		chk_st(16'h0000);
	endtask
	task automatic t_neg();
		sta.wr(phy_irq_pkg::ADDR_EVT_ENABLE, 16'h0082);
		neg = 1'b1;
		cyc(3);
		chk_irq(1'b1);
		chk_st(16'h0084);
		chk_irq(1'b0);
		chk_st(16'h0080);
	endtask
	task automatic t_mask();
		sta.wr(phy_irq_pkg::ADDR_EVT_ENABLE, 16'h0012);
		rate = ~rate;
		cyc(3);
		chk_irq(1'b0);
		link = ~link;
		cyc(3);
		chk_irq(1'b1);
		chk_st(16'h00D4);
		chk_irq(1'b0);
		sta.wr(phy_irq_pkg::ADDR_EVT_ENABLE, 16'h0010);
		link = ~link;
		cyc(3);
		chk_irq(1'b0);
		chk_st(16'h0090);
	endtask
	task automatic t_force();
		sta.wr(phy_irq_pkg::ADDR_EVT_ENABLE, 16'hFFFF);
		sta.rd(phy_irq_pkg::ADDR_EVT_ENABLE, v);
		cmp("enable", 16'h00F3, v);
		chk_irq(1'b1);
		chk_st(16'h0084);
		sta.wr(phy_irq_pkg::ADDR_EVT_ENABLE, 16'h0000);
		chk_irq(1'b0);
	endtask
	task automatic t_map();
		sta.wr(phy_irq_pkg::ADDR_EVT_STATUS, 16'hFFFF);
		chk_st(16'h0080);
		sta.rd(5'h14, v);
		cmp("unmapped", 16'h0000, v);
	endtask
	// ----------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------
	initial begin
		mismatches = 0;
		checks_done = 0;
		rstn = 1'b0;
		neg = 1'b0;
		rate = 1'b0;
		dup = 1'b0;
		link = 1'b0;
		cyc(2);
		rstn = 1'b1;
		// Change detection only starts on the second edge after reset
		cyc(2);
		t_reset();
		t_events();
		t_neg();
		t_mask();
		t_force();
		t_map();
		give_verdict();
	end
	initial begin
		cycles = 0;
		forever begin
			@(posedge clk);
			cycles++;
			if (cycles == 2000) begin
				mismatches++;
				give_verdict();
			end
		end
	end
endmodule
